// >>> include/aes_pkg.sv
// shared constants for the position encoder serial link
package aes_pkg;
	// ----------------------------------------
	// clock and link timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// biss timeout window 150-380 ns, sse within 375-605 ns
	localparam int BISS_TIMEOUT_NS = 200;
	localparam int SSI_TIMEOUT_NS = 450;
	localparam int BISS_TIMEOUT_CYC = BISS_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int SSI_TIMEOUT_CYC = SSI_TIMEOUT_NS / CLK_PERIOD_NS;
	// master side link clock phases
	localparam int BISS_HALF_NS = 100;
	localparam int SSI_HALF_NS = 130;
	localparam int BISS_HALF_CYC = (BISS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SSI_HALF_CYC = (SSI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// master waits this long for the start bit
	localparam int START_WAIT_CYC = 200;
	localparam logic [7:0] CNT_RST = 8'h00;
	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int TURN_W = 18;
	localparam int ANGLE_W = 20;
	localparam int POS_W = TURN_W + ANGLE_W;
	localparam int CRC_W = 6;
	// biss: pos, err, warn, crc; ack, start and cds go ahead of these and are not counted
	localparam int BISS_BITS = POS_W + 2 + CRC_W;
	// ssi: pos, err, warn
	localparam int SSI_BITS = POS_W + 2;
	localparam int SHIFT_W = 64;
	localparam logic [5:0] CRC_POLY = 6'h03;
	localparam logic [5:0] CRC_RST = 6'h00;
	// interface selection codes, a1 biss, a2 ssi
	typedef enum logic {AES_MODE_BISS, AES_MODE_SSI} aes_mode_t;
	localparam int BUF_DEPTH = 2;
endpackage

// >>> include/aes_link_if.sv
// link wires between encoder and master
`timescale 1ns/1ps
interface aes_link_if;
	logic link_clk;
	logic slo_o;
	logic slo_oe;
	logic slo;
	assign slo = slo_oe ? slo_o : 1'b1;
	modport enc (input link_clk, output slo_o, output slo_oe);
	modport mst (output link_clk, input slo);
endinterface

// >>> rtl/aes_encoder.sv
// encoder end: position keeping and serial slave
`timescale 1ns/1ps
// How it works
// R1: angle 19 or 20 bits by scale
// R2: revolution count eighteen bits, reported with angle
// R3: counting continues on battery power
// R4: biss-c bp3 framing in biss mode
// R5: biss master clock at most 5 mhz
// R6: biss clock high beyond timeout ends frame
// R7: ssi master clock at most 4 mhz
// R8: ssi clock high beyond timeout ends frame
// R9: error bit low on misalignment or shift
// R10: warning bit low on overspeed or weak field
// R11: per unit setting picks biss or ssi
// R12: after timeout, idle data, latch fresh position
module aes_encoder (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire aes_pkg::aes_mode_t i_mode,
	input wire logic i_res20,
	input wire logic i_step_valid,
	input wire logic i_step_dir,
	input wire logic i_battery_mode,
	input wire logic i_bad_align,
	input wire logic i_mech_shift,
	input wire logic i_overspeed,
	input wire logic i_weak_field,
	output logic o_led_red,
	output logic [aes_pkg::ANGLE_W-1:0] o_angle,
	output logic [aes_pkg::TURN_W-1:0] o_turns,
	aes_link_if.enc link
);
	typedef enum logic {ST_IDLE, ST_SHIFT} aes_state_t;
	aes_state_t state_r;
	logic clk_m_r, clk_s_r, clk_d_r;
	logic [aes_pkg::ANGLE_W-1:0] angle_r;
	logic [aes_pkg::TURN_W-1:0] turns_r;
	logic [aes_pkg::ANGLE_W-1:0] angle_max;
	logic [aes_pkg::SHIFT_W-1:0] shift_r, frame_nxt;
	logic [7:0] bits_r, tmo_r, tmo_lim;
	logic [aes_pkg::CRC_W-1:0] crc_nxt;
	logic err_n, warn_n, rise, fall;
	logic slo_r;
	// ----------------------------------------
	// link clock synchroniser
	// ----------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			clk_m_r <= 1'b1;
			clk_s_r <= 1'b1;
			clk_d_r <= 1'b1;
		end else begin
			clk_m_r <= link.link_clk;
			clk_s_r <= clk_m_r;
			clk_d_r <= clk_s_r;
		end
	end
	assign rise = clk_s_r & ~clk_d_r;
	assign fall = ~clk_s_r & clk_d_r;
	// ----------------------------------------
	// position keeping
	// ----------------------------------------
	// R1: resolution from scale size
	assign angle_max = i_res20 ? 20'hFFFFF : 20'h7FFFF;
	// R2: angle wraps into turn count
	// R3: steps counted whatever the supply
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			angle_r <= '0;
			turns_r <= '0;
		end else if (i_step_valid) begin
			if (i_step_dir) begin
				angle_r <= (angle_r >= angle_max) ? '0 : angle_r + 20'h00001;
				if (angle_r >= angle_max)
					turns_r <= turns_r + 18'h00001;
			end else begin
				angle_r <= (angle_r == '0) ? angle_max : angle_r - 20'h00001;
				if (angle_r == '0)
					turns_r <= turns_r - 18'h00001;
			end
		end
	end
	assign o_angle = angle_r;
	assign o_turns = turns_r;
	// R9: error low on alignment fault
	assign err_n = ~(i_bad_align | i_mech_shift);
	assign o_led_red = ~err_n;
	// R10: warning low on speed or field
	assign warn_n = ~(i_overspeed | i_weak_field);
	// ----------------------------------------
	// frame build
	// ----------------------------------------
	always_comb begin
		logic [aes_pkg::POS_W+1:0] payload;
		logic fb;
		fb = 1'b0;
		payload = {turns_r, angle_r, err_n, warn_n};
		crc_nxt = aes_pkg::CRC_RST;
		// R4: bp3 crc over position and status
		for (int i = aes_pkg::POS_W + 1; i >= 0; i--) begin
			fb = crc_nxt[5] ^ payload[i];
			crc_nxt = {crc_nxt[4:0], 1'b0} ^ (fb ? aes_pkg::CRC_POLY : 6'h00);
		end
		crc_nxt = ~crc_nxt;
		// R11: layout chosen by mode setting
		if (i_mode == aes_pkg::AES_MODE_BISS)
			// ack low, start high, cds low ahead of the word
			frame_nxt = {3'b010, payload, crc_nxt, 15'h0000};
		else
			frame_nxt = {payload, 24'h000000};
	end
	// R6: biss timeout, R8: ssi timeout
	assign tmo_lim = (i_mode == aes_pkg::AES_MODE_BISS) ? 8'(aes_pkg::BISS_TIMEOUT_CYC)
		: 8'(aes_pkg::SSI_TIMEOUT_CYC);
	// ----------------------------------------
	// serial slave
	// ----------------------------------------
	// data changes on rising edge, master samples on falling
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state_r <= ST_IDLE;
			shift_r <= '0;
			bits_r <= aes_pkg::CNT_RST;
			tmo_r <= aes_pkg::CNT_RST;
			slo_r <= 1'b1;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					slo_r <= 1'b1;
					tmo_r <= aes_pkg::CNT_RST;
					if (fall) begin
						state_r <= ST_SHIFT;
						shift_r <= frame_nxt;
						bits_r <= aes_pkg::CNT_RST;
					end
				end
				ST_SHIFT: begin
					if (rise) begin
						slo_r <= shift_r[aes_pkg::SHIFT_W-1];
						shift_r <= {shift_r[aes_pkg::SHIFT_W-2:0], 1'b0};
						bits_r <= bits_r + 8'h01;
					end
					if (!clk_s_r)
						tmo_r <= aes_pkg::CNT_RST;
					else
						tmo_r <= tmo_r + 8'h01;
					// R6: long high ends frame
					// R8: long high ends frame
					// R12: idle level, fresh latch next frame
					// no second busy phase, so a master restarting after one timeout is seen
					if (clk_s_r && tmo_r >= tmo_lim) begin
						state_r <= ST_IDLE;
						slo_r <= 1'b1;
						tmo_r <= aes_pkg::CNT_RST;
					end
				end
			endcase
		end
	end
	assign link.slo_o = slo_r;
	assign link.slo_oe = 1'b1;
endmodule

// >>> rtl/aes_master.sv
// master end: link clock generator and frame reader
`timescale 1ns/1ps
module aes_master (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire aes_pkg::aes_mode_t i_mode,
	input wire logic i_read,
	output logic o_busy,
	output logic o_valid,
	input wire logic i_ready,
	output logic [aes_pkg::POS_W+1:0] o_data,
	output logic o_crc_err,
	aes_link_if.mst link
);
	typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_WAIT} aes_mstate_t;
	aes_mstate_t state_r;
	logic sd_m_r, sd_s_r, clk_r, started_r, done_r;
	logic [7:0] cnt_r, bits_r, half, need;
	logic [aes_pkg::SHIFT_W-1:0] rx_r;
	logic [aes_pkg::POS_W+1:0] word;
	logic [aes_pkg::CRC_W-1:0] crc_c;
	logic push, push_ok, bad;
	logic [aes_pkg::POS_W+2:0] buf_r [aes_pkg::BUF_DEPTH];
	logic [1:0] cnt_q_r;
	logic wp_r, rp_r;
	// ----------------------------------------
	// data synchroniser
	// ----------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sd_m_r <= 1'b1;
			sd_s_r <= 1'b1;
		end else begin
			sd_m_r <= link.slo;
			sd_s_r <= sd_m_r;
		end
	end
	// R5: biss half period 100 ns; R7: ssi 125 ns or more
	assign half = (i_mode == aes_pkg::AES_MODE_BISS) ? 8'(aes_pkg::BISS_HALF_CYC) : 8'(aes_pkg::SSI_HALF_CYC);
	// biss count includes the cds bit ahead of the word
	assign need = (i_mode == aes_pkg::AES_MODE_BISS) ? 8'(aes_pkg::BISS_BITS + 1)
		: 8'(aes_pkg::SSI_BITS);
	// ----------------------------------------
	// clock and capture
	// ----------------------------------------
	// data reaches the sampler five cycles after the rising edge; half period covers it
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state_r <= ST_IDLE;
			clk_r <= 1'b1;
			cnt_r <= aes_pkg::CNT_RST;
			bits_r <= aes_pkg::CNT_RST;
			started_r <= 1'b0;
			done_r <= 1'b0;
			rx_r <= '0;
		end else begin
			done_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					clk_r <= 1'b1;
					cnt_r <= aes_pkg::CNT_RST;
					bits_r <= aes_pkg::CNT_RST;
					started_r <= 1'b0;
					if (i_read && sd_s_r && push_ok) begin
						state_r <= ST_LOW;
						clk_r <= 1'b0;
					end
				end
				ST_LOW: begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r + 8'h01 >= half) begin
						state_r <= ST_HIGH;
						clk_r <= 1'b1;
						cnt_r <= aes_pkg::CNT_RST;
					end
				end
				ST_HIGH: begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r + 8'h01 >= half) begin
						cnt_r <= aes_pkg::CNT_RST;
						// R4: biss waits ack then start bit
						if (i_mode == aes_pkg::AES_MODE_BISS && !started_r) begin
							if (sd_s_r && bits_r != 8'h00) begin
								started_r <= 1'b1;
								bits_r <= aes_pkg::CNT_RST;
								state_r <= ST_LOW;
								clk_r <= 1'b0;
							end else if (bits_r >= 8'(aes_pkg::START_WAIT_CYC)) begin
								state_r <= ST_WAIT;
							end else begin
								bits_r <= bits_r + 8'h01;
								state_r <= ST_LOW;
								clk_r <= 1'b0;
							end
						end else begin
							// counted from cds in biss, from the first bit in ssi
							rx_r <= {rx_r[aes_pkg::SHIFT_W-2:0], sd_s_r};
							bits_r <= bits_r + 8'h01;
							if (bits_r + 8'h01 >= need) begin
								state_r <= ST_WAIT;
								done_r <= 1'b1;
							end else begin
								state_r <= ST_LOW;
								clk_r <= 1'b0;
							end
						end
					end
				end
				ST_WAIT: begin
					// R6: clock held high past timeout
					// R8: clock held high past timeout
					clk_r <= 1'b1;
					if (sd_s_r && cnt_r > 8'(aes_pkg::SSI_TIMEOUT_CYC))
						state_r <= ST_IDLE;
					else
						cnt_r <= cnt_r + 8'h01;
				end
			endcase
		end
	end
	assign link.link_clk = clk_r;
	assign o_busy = (state_r != ST_IDLE);
	// ----------------------------------------
	// frame check
	// ----------------------------------------
	always_comb begin
		logic fb;
		fb = 1'b0;
		crc_c = aes_pkg::CRC_RST;
		if (i_mode == aes_pkg::AES_MODE_BISS)
			word = rx_r[aes_pkg::CRC_W +: aes_pkg::POS_W + 2];
		else
			word = rx_r[aes_pkg::POS_W+1:0];
		for (int i = aes_pkg::POS_W + 1; i >= 0; i--) begin
			fb = crc_c[5] ^ word[i];
			crc_c = {crc_c[4:0], 1'b0} ^ (fb ? aes_pkg::CRC_POLY : 6'h00);
		end
		crc_c = ~crc_c;
		bad = (i_mode == aes_pkg::AES_MODE_BISS) && (crc_c != rx_r[aes_pkg::CRC_W-1:0]);
	end
	// pushed one cycle after the last bit, once rx_r holds the whole frame
	assign push = done_r;
	// ----------------------------------------
	// two-entry buffer
	// ----------------------------------------
	// a start is refused while the buffer is full, so no word is lost
	assign push_ok = (cnt_q_r != 2'(aes_pkg::BUF_DEPTH));
	assign o_valid = (cnt_q_r != 2'h0);
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cnt_q_r <= 2'h0;
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			buf_r[0] <= '0;
			buf_r[1] <= '0;
		end else begin
			if (push) begin
				buf_r[wp_r] <= {bad, word};
				wp_r <= ~wp_r;
			end
			if (o_valid && i_ready)
				rp_r <= ~rp_r;
			cnt_q_r <= cnt_q_r + 2'(push) - 2'(o_valid && i_ready);
		end
	end
	assign o_data = buf_r[rp_r][aes_pkg::POS_W+1:0];
	assign o_crc_err = buf_r[rp_r][aes_pkg::POS_W+2];
endmodule

// >>> verification/aes_link_checker.sv
// link timing and data checks for the encoder link
`timescale 1ns/1ps
module aes_link_checker (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire aes_pkg::aes_mode_t i_mode,
	input wire logic link_clk,
	input wire logic slo_o,
	input wire logic slo_oe,
	input wire logic slo
);
	// ----------------------------------------
	// phase counters
	// ----------------------------------------
	logic [7:0] hi_r;
	logic [7:0] lo_r;
	logic [7:0] last_hi_r;
	int half;
	int per;
	int to;
	assign half = (i_mode == aes_pkg::AES_MODE_SSI) ? 13 : 10;
	assign per = (i_mode == aes_pkg::AES_MODE_SSI) ? 25 : 20;
	assign to = (i_mode == aes_pkg::AES_MODE_SSI) ? aes_pkg::SSI_TIMEOUT_CYC : aes_pkg::BISS_TIMEOUT_CYC;
	// idle after reset counts as a long high, so the first frame is not misjudged
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			hi_r <= 8'hFF;
			lo_r <= 8'h00;
			last_hi_r <= 8'hFF;
		end else begin
			hi_r <= link_clk ? hi_r + {7'h00, hi_r != 8'hFF} : 8'h00;
			lo_r <= link_clk ? 8'h00 : lo_r + 8'h01;
			if (!link_clk && hi_r != 8'h00) last_hi_r <= hi_r;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESETN);
	property p_low_min;
		$rose(link_clk) |-> lo_r >= half;
	endproperty
	a_low_min: assert property (p_low_min) else $error("link clock low too short");
	property p_high_min;
		$fell(link_clk) |-> hi_r >= half;
	endproperty
	a_high_min: assert property (p_high_min) else $error("link clock high too short");
	property p_period;
		$rose(link_clk) |-> int'(lo_r) + int'(last_hi_r) >= per;
	endproperty
	a_period: assert property (p_period) else $error("link clock period too short");
	property p_high_timeout;
		$fell(link_clk) |-> (hi_r < to) || (hi_r > to);
	endproperty
	a_high_timeout: assert property (p_high_timeout) else $error("high phase sits on timeout");
	property p_idle_data;
		link_clk && hi_r >= to + 6 |-> slo;
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("data not idle after timeout");
	property p_data_steady;
		link_clk && hi_r >= 6 && hi_r < half |-> $stable(slo);
	endproperty
	a_data_steady: assert property (p_data_steady) else $error("data moved near sample point");
	property p_biss_ack;
		i_mode == aes_pkg::AES_MODE_BISS && $fell(link_clk) && hi_r > to |-> ##[1:60] !slo;
	endproperty
	a_biss_ack: assert property (p_biss_ack) else $error("no acknowledge low in frame");
	property p_drive;
		slo_oe && slo == slo_o;
	endproperty
	a_drive: assert property (p_drive) else $error("data line not driven");
endmodule

// >>> verification/tb_absolute_encoder_serial_slave.sv
// self-checking bench for the encoder and master pair
`timescale 1ns/1ps
module tb_absolute_encoder_serial_slave;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	aes_pkg::aes_mode_t mode = aes_pkg::AES_MODE_BISS;
	logic res20 = 1'b0;
	logic stp = 1'b0;
	logic dir = 1'b0;
	logic bat = 1'b0;
	logic [3:0] flt = 4'h0;
	logic rd = 1'b0;
	logic rdy = 1'b1;
	logic hold = 1'b0;
	logic led, busy, vld, crc_err;
	logic [19:0] ang_o;
	logic [17:0] trn_o;
	logic [39:0] dat;
	logic [40:0] e;
	logic [40:0] q[$];
	logic [19:0] ang = 20'h00000;
	logic [17:0] trn = 18'h00000;
	logic [31:0] lf = 32'h1735D83F;
	int num_errors = 0;
	int n_compared = 0;
	aes_link_if link ();
	always #5 clk = ~clk;
	aes_encoder u_aes_encoder (.I_REF_CLK(clk), .I_RESETN(rst_n), .i_mode(mode), .i_res20(res20),
		.i_step_valid(stp), .i_step_dir(dir), .i_battery_mode(bat), .i_bad_align(flt[0]),
		.i_mech_shift(flt[1]), .i_overspeed(flt[2]), .i_weak_field(flt[3]), .o_led_red(led),
		.o_angle(ang_o), .o_turns(trn_o), .link(link));
	aes_master u_aes_master (.I_REF_CLK(clk), .I_RESETN(rst_n), .i_mode(mode), .i_read(rd), .o_busy(busy),
		.o_valid(vld), .i_ready(rdy), .o_data(dat), .o_crc_err(crc_err), .link(link));
	aes_link_checker u_aes_link_checker (.I_REF_CLK(clk), .I_RESETN(rst_n), .i_mode(mode),
		.link_clk(link.link_clk), .slo_o(link.slo_o), .slo_oe(link.slo_oe), .slo(link.slo));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic cmp_word(input logic [40:0] got, input logic [40:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({40'h0000000000, got}, {40'h0000000000, exp});
	endtask
	task automatic step(input logic d, input int n);
		logic [19:0] mx;
		mx = res20 ? 20'hFFFFF : 20'h7FFFF;
		for (int i = 0; i < n; i++) begin
			dir = d;
			stp = 1'b1;
			@(negedge clk);
			stp = 1'b0;
			@(negedge clk);
			if (d) {trn, ang} = (ang == mx) ? {trn + 18'h00001, 20'h00000} : {trn, ang + 20'h00001};
			else {trn, ang} = (ang == 20'h00000) ? {trn - 18'h00001, mx} : {trn, ang - 20'h00001};
		end
	endtask
	// skip only for a frame that may carry an older latch
	task automatic rdf(input logic skip);
		q.push_back({skip, trn, ang, ~(flt[0] | flt[1]), ~(flt[2] | flt[3])});
		rd = 1'b1;
		@(negedge clk);
		for (int k = 0; k < 500 && busy !== 1'b1; k++) @(negedge clk);
		rd = 1'b0;
		for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk);
		repeat (100) @(negedge clk);
	endtask
	task automatic test_done();
		$display("compares %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// ready stalls and result monitor
	// ----------------------------------------
	always @(negedge clk) begin
		lf = nx(lf);
		rdy = !hold && (lf[1:0] != 2'h0);
		if (vld === 1'b1 && rdy) begin
			e = (q.size() > 0) ? q.pop_front() : {1'b0, ~crc_err, ~dat};
			if (!e[40]) cmp_word({crc_err, dat}, {1'b0, e[39:0]});
		end
	end
	initial begin
		#600000;
		num_errors++;
		test_done();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		for (int m = 0; m < 4; m++) begin
			mode = aes_pkg::aes_mode_t'(m[0]);
			res20 = m[1];
			bat = m[0];
			flt = lf[5:2];
			step(1'b0, 2);
			step(1'b1, 1 + int'(lf[7:5]));
			cmp_word({3'h0, trn_o, ang_o}, {3'h0, trn, ang});
			cmp_bit(led, flt[0] | flt[1]);
			rdf(1'b0);
			rdf(1'b0);
			$display("test mode %0d done", m);
		end
		// buffer fills, third frame refused, then drains
		hold = 1'b1;
		repeat (2) q.push_back({1'b0, trn, ang, ~(flt[0] | flt[1]), ~(flt[2] | flt[3])});
		rd = 1'b1;
		repeat (4000) @(negedge clk);
		cmp_bit(busy, 1'b0);
		cmp_bit(vld, 1'b1);
		rd = 1'b0;
		hold = 1'b0;
		repeat (200) @(negedge clk);
		$display("test buffer done");
		// reset in mid-frame, then a clean read from zero
		rd = 1'b1;
		repeat (300) @(negedge clk);
		rst_n = 1'b0;
		q.delete();
		{trn, ang} = 38'h0000000000;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd = 1'b0;
		repeat (3) @(negedge clk);
		rdf(1'b0);
		rdf(1'b0);
		cmp_word({9'h000, q.size()}, 41'h00000000000);
		$display("test reset done");
		test_done();
	end
endmodule
